/* File: rtl/pmp_port.sv */
// file: parallel master/slave port with apb registers and interrupt
// assumes: all pin inputs synchronous to clk_sys; apb master per amba spec
//
// Operation
// - byte enable polarity follows its control bit
// - write strobe polarity in slave, master two
// - master one: bit sets enable strobe polarity
// - read strobe polarity in slave, master two
// - master one: bit sets read/write polarity
// - polarity ignored when pin carries address
// - small package: address lines ten..two absent
// - zero strobe wait ignores setup, hold
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module pmp_port
    import pmp_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // clock and reset
    input  wire logic     clk_sys,
    input  wire logic     nrst,
    // register bus
    input  wire apb_req_t apbReq,
    output apb_rsp_t      apbRsp,
    // port pins
    output pin_out_t      pinOut,
    input  wire logic [7:0] portDataIn,
    input  wire logic     writeStrobeIn,
    input  wire logic     readStrobeIn,
    // interrupt
    output logic          irq
);
    typedef struct packed {
        logic [15:0]      control;
        logic [15:0]      mode;
        logic [15:0]      txData;
        logic [15:0]      rxData;
        logic [10:0]      addr;
        logic [IRQ_W-1:0] irqStatus;
        logic [IRQ_W-1:0] irqEnable;
        xfer_state_t      st;
        logic [3:0]       cnt;
        logic             secondByte;
        logic             isRead;
        logic             slaveWrPrev;
        pin_out_t         pins;
        apb_rsp_t         rsp;
        logic             irq;
    } core_t;

    core_t q;
    core_t d;

    logic             beAsAddr;
    logic             startXfer;
    logic             byteDone;
    logic             nextByte;
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] irqClr;
    logic [3:0]       waitCnt;
    logic             waitOn;
    logic             masterOn;
    logic             slaveOn;
    logic             slaveWr;
    logic             slaveRd;
    logic             pinBe;
    logic             pinWr;
    logic             pinRd;
    logic             pinCs;

    function automatic logic isMapped(input logic [7:0] a);
        if (a == OFF_CONTROL || a == OFF_MODE || a == OFF_DATA) begin
            isMapped = 1'b1;
        end else if (a == OFF_ADDR || a == OFF_IRQ_STATUS) begin
            isMapped = 1'b1;
        end else if (a == OFF_IRQ_CLEAR || a == OFF_IRQ_ENABLE) begin
            isMapped = 1'b1;
        end else begin
            isMapped = 1'b0;
        end
    endfunction : isMapped

    function automatic logic [31:0] readMux(input core_t s, input logic [7:0] a);
        if (a == OFF_CONTROL) begin
            readMux = {16'h0000, s.control};
        end else if (a == OFF_MODE) begin
            readMux = {16'h0000, s.mode};
        end else if (a == OFF_DATA) begin
            readMux = {16'h0000, s.rxData};
        end else if (a == OFF_ADDR) begin
            readMux = {21'h00_0000, s.addr};
        end else if (a == OFF_IRQ_STATUS) begin
            readMux = {29'h0000_0000, s.irqStatus};
        end else if (a == OFF_IRQ_ENABLE) begin
            readMux = {29'h0000_0000, s.irqEnable};
        end else begin
            readMux = 32'h0000_0000;
        end
    endfunction : readMux

    assign waitCnt  = q.mode[MODE_WAIT_HI:MODE_WAIT_LO];
    assign waitOn   = (waitCnt != 4'h0);
    assign masterOn = q.control[CTL_ENABLE] && q.mode[MODE_SEL_HI];
    assign slaveOn  = q.control[CTL_ENABLE] && !q.mode[MODE_SEL_HI];
    assign beAsAddr = !q.mode[MODE_WIDE] && (q.control[CTL_MUX_HI:CTL_MUX_LO] != MUX_NONE);
    assign slaveWr  = slaveOn && polarize(writeStrobeIn, q.control[CTL_WR_POL]);
    assign slaveRd  = slaveOn && polarize(readStrobeIn, q.control[CTL_RD_POL]);

    pmp_strobe_drive u_strobe (
        .control       (q.control),
        .portMode      (q.mode[MODE_SEL_HI:MODE_SEL_LO]),
        .beAsAddr      (beAsAddr),
        .addrBit       (q.addr[0]),
        .strobeOn      (d.st == XS_STROBE),
        .xferOn        (d.st != XS_IDLE),
        .isRead        (d.isRead),
        .wide          (q.mode[MODE_WIDE]),
        .byteEnable    (pinBe),
        .writeStrobe   (pinWr),
        .readStrobe    (pinRd),
        .chipSelectOne (pinCs)
    );

    always_comb begin
        d         = q;
        startXfer = 1'b0;
        byteDone  = 1'b0;
        nextByte  = 1'b0;
        irqSet    = '0;
        irqClr    = '0;
        // apb: first access cycle answers, second commits
        d.rsp.pready = 1'b0;
        if (apbReq.psel && apbReq.penable && !q.rsp.pready) begin
            d.rsp.pready  = 1'b1;
            d.rsp.pslverr = !isMapped(apbReq.paddr);
            d.rsp.prdata  = apbReq.pwrite ? 32'h0000_0000 : readMux(q, apbReq.paddr);
        end
        if (apbReq.psel && apbReq.penable && q.rsp.pready) begin
            if (apbReq.pwrite) begin
                if (apbReq.paddr == OFF_CONTROL) begin
                    d.control = apbReq.pwdata[15:0] & CONTROL_WMASK;
                end else if (apbReq.paddr == OFF_MODE) begin
                    d.mode = (q.mode & ~MODE_WMASK) | (apbReq.pwdata[15:0] & MODE_WMASK);
                end else if (apbReq.paddr == OFF_DATA) begin
                    if (q.st != XS_IDLE) begin
                        irqSet[IRQ_OVERRUN] = 1'b1;
                    end else begin
                        d.txData  = apbReq.pwdata[15:0];
                        d.isRead  = 1'b0;
                        startXfer = masterOn;
                    end
                end else if (apbReq.paddr == OFF_ADDR) begin
                    d.addr = apbReq.pwdata[10:0];
                end else if (apbReq.paddr == OFF_IRQ_CLEAR) begin
                    irqClr = apbReq.pwdata[IRQ_W-1:0];
                end else if (apbReq.paddr == OFF_IRQ_ENABLE) begin
                    d.irqEnable = apbReq.pwdata[IRQ_W-1:0];
                end
            end else if (apbReq.paddr == OFF_DATA && masterOn) begin
                // reading data launches the next master read
                if (q.st != XS_IDLE) begin
                    irqSet[IRQ_OVERRUN] = 1'b1;
                end else begin
                    d.isRead  = 1'b1;
                    startXfer = 1'b1;
                end
            end
        end
        // master transfer engine
        case (q.st)
            XS_IDLE: begin
                if (startXfer) begin
                    d.secondByte = 1'b0;
                    nextByte     = 1'b1;
                end
            end
            XS_SETUP: begin
                if (q.cnt == 4'h0) begin
                    d.st  = XS_STROBE;
                    d.cnt = waitCnt;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            XS_STROBE: begin
                if (q.cnt == 4'h0) begin
                    if (q.isRead && q.secondByte) begin
                        d.rxData[15:8] = portDataIn;
                    end else if (q.isRead) begin
                        d.rxData[7:0] = portDataIn;
                    end
                    if (waitOn) begin
                        d.st  = XS_HOLD;
                        d.cnt = {2'b00, q.mode[MODE_HOLD_HI:MODE_HOLD_LO]};
                    end else begin
                        byteDone = 1'b1;
                    end
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            XS_HOLD: begin
                if (q.cnt == 4'h0) begin
                    byteDone = 1'b1;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            default: begin
                d.st = XS_IDLE;
            end
        endcase
        if (byteDone) begin
            if (q.mode[MODE_INC_HI:MODE_INC_LO] == INC_UP) begin
                d.addr = q.addr + 11'h001;
            end else if (q.mode[MODE_INC_HI:MODE_INC_LO] == INC_DOWN) begin
                d.addr = q.addr - 11'h001;
            end
            if (q.mode[MODE_WIDE] && !q.secondByte) begin
                d.secondByte = 1'b1;
                nextByte     = 1'b1;
            end else begin
                d.st               = XS_IDLE;
                irqSet[IRQ_DONE]   = 1'b1;
            end
        end
        if (nextByte) begin
            // zero strobe wait skips setup and hold
            d.st  = waitOn ? XS_SETUP : XS_STROBE;
            d.cnt = waitOn ? {2'b00, q.mode[MODE_SETUP_HI:MODE_SETUP_LO]} : waitCnt;
        end
        d.mode[MODE_BUSY] = (d.st != XS_IDLE);
        // slave side: latch on the leading edge of the write strobe
        d.slaveWrPrev = slaveWr;
        if (slaveWr && !q.slaveWrPrev) begin
            d.rxData[7:0]     = portDataIn;
            irqSet[IRQ_SLAVE] = 1'b1;
        end
        // pins
        d.pins.portData   = d.secondByte ? d.txData[15:8] : d.txData[7:0];
        if (slaveRd) begin
            d.pins.portData = q.txData[7:0];
        end
        d.pins.portDataOe    = slaveRd || (masterOn && d.st != XS_IDLE && !d.isRead);
        d.pins.portAddr      = SMALL_PACKAGE ? {9'h000, d.addr[1:0]} : d.addr;
        d.pins.byteEnable    = pinBe;
        d.pins.writeStrobe   = pinWr;
        d.pins.readStrobe    = pinRd;
        d.pins.chipSelectOne = pinCs;
        // interrupt: set wins over clear
        d.irqStatus = (q.irqStatus & ~irqClr) | irqSet;
        d.irq       = |(d.irqStatus & d.irqEnable);
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            q         <= '0;
            q.control <= CONTROL_RESET;
            q.mode    <= MODE_RESET;
            q.st      <= XS_IDLE;
            q.pins.writeStrobe   <= 1'b1;
            q.pins.readStrobe    <= 1'b1;
            q.pins.byteEnable    <= 1'b1;
            q.pins.chipSelectOne <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign apbRsp = q.rsp;
    assign pinOut = q.pins;
    assign irq    = q.irq;

    // checks
    property p_be_active;
        @(posedge clk_sys) disable iff (!nrst)
        (d.st == XS_STROBE && q.mode[MODE_WIDE] && !beAsAddr && $stable(q.control))
        |=> q.pins.byteEnable == $past(q.control[CTL_BE_POL]);
    endproperty
    a_be_active: assert property (p_be_active) else $error("byte enable level");

    property p_wr_master2;
        @(posedge clk_sys) disable iff (!nrst)
        (q.mode[MODE_SEL_HI:MODE_SEL_LO] == PM_MASTER2 && d.st == XS_STROBE && !d.isRead)
        |=> q.pins.writeStrobe == $past(q.control[CTL_WR_POL]);
    endproperty
    a_wr_master2: assert property (p_wr_master2) else $error("write strobe level");

    property p_en_master1;
        @(posedge clk_sys) disable iff (!nrst)
        (q.mode[MODE_SEL_HI:MODE_SEL_LO] == PM_MASTER1 && d.st != XS_STROBE)
        |=> q.pins.writeStrobe == !$past(q.control[CTL_WR_POL]);
    endproperty
    a_en_master1: assert property (p_en_master1) else $error("enable strobe level");

    property p_rd_master2;
        @(posedge clk_sys) disable iff (!nrst)
        (q.mode[MODE_SEL_HI:MODE_SEL_LO] == PM_MASTER2 && d.st == XS_STROBE && d.isRead)
        |=> q.pins.readStrobe == $past(q.control[CTL_RD_POL]);
    endproperty
    a_rd_master2: assert property (p_rd_master2) else $error("read strobe level");

    property p_rw_master1;
        @(posedge clk_sys) disable iff (!nrst)
        (q.mode[MODE_SEL_HI:MODE_SEL_LO] == PM_MASTER1 && d.st != XS_IDLE)
        |=> q.pins.readStrobe == ($past(q.control[CTL_RD_POL]) ~^ $past(d.isRead));
    endproperty
    a_rw_master1: assert property (p_rw_master1) else $error("read/write level");

    property p_be_addr;
        @(posedge clk_sys) disable iff (!nrst)
        beAsAddr |=> q.pins.byteEnable == $past(q.addr[0]);
    endproperty
    a_be_addr: assert property (p_be_addr) else $error("address pin polarized");

    property p_busy;
        @(posedge clk_sys) disable iff (!nrst)
        startXfer |=> q.mode[MODE_BUSY];
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag wrong");

    property p_small_pkg;
        @(posedge clk_sys) disable iff (!nrst)
        SMALL_PACKAGE |-> q.pins.portAddr[10:2] == 9'h000;
    endproperty
    a_small_pkg: assert property (p_small_pkg) else $error("upper address driven");

    property p_no_wait;
        @(posedge clk_sys) disable iff (!nrst)
        (q.st == XS_IDLE && startXfer && !waitOn) |=> q.st == XS_STROBE ##1 q.st != XS_HOLD;
    endproperty
    a_no_wait: assert property (p_no_wait) else $error("setup or hold used");

    property p_wide_two;
        @(posedge clk_sys) disable iff (!nrst)
        (byteDone && q.mode[MODE_WIDE] && !q.secondByte) |=> q.st != XS_IDLE && q.secondByte;
    endproperty
    a_wide_two: assert property (p_wide_two) else $error("second byte missing");

endmodule : pmp_port

/* File: rtl/pmp_pkg.sv */
// package: offsets, fields, reset values and carriers of the parallel port
// assumes: 32-bit apb, one clock clk_sys, 16-bit registers in the low lanes
package pmp_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CONTROL    = 8'h00;
    localparam logic [7:0] OFF_MODE       = 8'h04;
    localparam logic [7:0] OFF_DATA       = 8'h08;
    localparam logic [7:0] OFF_ADDR       = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h14;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;

    // port_control fields
    localparam int CTL_ENABLE  = 15;
    localparam int CTL_MUX_HI  = 12;
    localparam int CTL_MUX_LO  = 11;
    localparam int CTL_CS_POL  = 3;
    localparam int CTL_BE_POL  = 2;
    localparam int CTL_WR_POL  = 1;
    localparam int CTL_RD_POL  = 0;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_WMASK = 16'hBFEF;

    // port_mode fields
    localparam int MODE_BUSY     = 15;
    localparam int MODE_INC_HI   = 12;
    localparam int MODE_INC_LO   = 11;
    localparam int MODE_WIDE     = 10;
    localparam int MODE_SEL_HI   = 9;
    localparam int MODE_SEL_LO   = 8;
    localparam int MODE_SETUP_HI = 7;
    localparam int MODE_SETUP_LO = 6;
    localparam int MODE_WAIT_HI  = 5;
    localparam int MODE_WAIT_LO  = 2;
    localparam int MODE_HOLD_HI  = 1;
    localparam int MODE_HOLD_LO  = 0;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] MODE_WMASK = 16'h7FFF;

    // port mode, address mux and increment selections
    localparam logic [1:0] PM_SLAVE_LEGACY = 2'b00;
    localparam logic [1:0] PM_SLAVE_BUF    = 2'b01;
    localparam logic [1:0] PM_MASTER2      = 2'b10;
    localparam logic [1:0] PM_MASTER1      = 2'b11;
    localparam logic [1:0] MUX_NONE        = 2'b00;
    localparam logic [1:0] INC_UP          = 2'b01;
    localparam logic [1:0] INC_DOWN        = 2'b10;

    // interrupt status bits
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_SLAVE   = 2;
    localparam int IRQ_W       = 3;

    typedef enum logic [1:0] {XS_IDLE, XS_SETUP, XS_STROBE, XS_HOLD} xfer_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [7:0]  portData;
        logic        portDataOe;
        logic [10:0] portAddr;
        logic        byteEnable;
        logic        writeStrobe;
        logic        readStrobe;
        logic        chipSelectOne;
    } pin_out_t;

    // active level to pin level
    function automatic logic polarize(input logic active, input logic highTrue);
        polarize = highTrue ? active : ~active;
    endfunction : polarize

endpackage : pmp_pkg

/* File: rtl/pmp_strobe_drive.sv */
// file: strobe pin polarity and function selection
// assumes: activity flags come from the transfer engine of pmp_port
`timescale 1ns/1ns
module pmp_strobe_drive
    import pmp_pkg::*;
(
    // configuration
    input  wire logic [15:0] control,
    input  wire logic [1:0]  portMode,
    input  wire logic        beAsAddr,
    input  wire logic        addrBit,
    // activity
    input  wire logic        strobeOn,
    input  wire logic        xferOn,
    input  wire logic        isRead,
    input  wire logic        wide,
    // pin levels
    output logic             byteEnable,
    output logic             writeStrobe,
    output logic             readStrobe,
    output logic             chipSelectOne
);
    always_comb begin
        // byte enable, or plain address line
        byteEnable = beAsAddr ? addrBit
                   : polarize(xferOn && wide, control[CTL_BE_POL]);
        if (portMode == PM_MASTER1) begin
            // enable strobe and combined read/write line
            writeStrobe = polarize(strobeOn, control[CTL_WR_POL]);
            readStrobe  = polarize(xferOn && isRead, control[CTL_RD_POL]);
        end else begin
            writeStrobe = polarize(strobeOn && !isRead, control[CTL_WR_POL]);
            readStrobe  = polarize(strobeOn && isRead, control[CTL_RD_POL]);
        end
        chipSelectOne = polarize(xferOn, control[CTL_CS_POL]);
    end
endmodule : pmp_strobe_drive

/* File: testbench/pmp_peer.sv */
// partner: external parallel peripheral or host on the port pins
// assumes: bench mirrors the polarity bits it programs into the port
`timescale 1ns/1ns
module pmp_peer
    import pmp_pkg::*;
(
    // clock
    input  wire logic       clk_sys,
    // bench settings
    input  wire logic       wrPol,
    input  wire logic       rdPol,
    input  wire logic       csPol,
    input  wire logic [7:0] rdByte,
    input  wire logic       slvWr,
    input  wire logic       slvRd,
    input  wire logic [7:0] slvByte,
    // pins
    input  wire pin_out_t   pinOut,
    output logic [7:0]      portDataIn,
    output logic            writeStrobeIn,
    output logic            readStrobeIn
);
    logic [7:0] junkQ;

    // released data lines wander every cycle
    initial junkQ = 8'h5A;
    always @(posedge clk_sys) begin
        junkQ <= ~junkQ + 8'h01;
    end

    always_comb begin
        writeStrobeIn = slvWr ? wrPol : ~wrPol;
        readStrobeIn = slvRd ? rdPol : ~rdPol;
        if (slvWr)
            portDataIn = slvByte;
        else if (pinOut.chipSelectOne == csPol && !pinOut.portDataOe)
            portDataIn = rdByte;
        else
            portDataIn = junkQ;
    end
endmodule : pmp_peer

/* File: testbench/tb_top.sv */
// testbench: register, pin polarity, transfer and interrupt checks of the port
// assumes: small package build, peer model on the pins, apb master below
`timescale 1ns/1ns
module tb_top
    import pmp_pkg::*;
;
    logic        clk_sys;
    logic        nrst;
    logic        irq;
    logic        wrPol;
    logic        rdPol;
    logic        slvWr;
    logic        slvRd;
    logic [7:0]  rdByte;
    logic [7:0]  slvByte;
    logic [7:0]  portDataIn;
    logic        writeStrobeIn;
    logic        readStrobeIn;
    apb_req_t    apbReq;
    apb_rsp_t    apbRsp;
    pin_out_t    pinOut;
    int          failCount;
    int          checksDone;
    int          cyc;
    int          dc;
    logic [15:0] db;
    logic [31:0] seed;
    logic [31:0] rd;
    logic        err;

    pmp_port #(.SMALL_PACKAGE(1'b1)) u_pmp_port (.clk_sys(clk_sys), .nrst(nrst),
        .apbReq(apbReq), .apbRsp(apbRsp), .pinOut(pinOut), .portDataIn(portDataIn),
        .writeStrobeIn(writeStrobeIn), .readStrobeIn(readStrobeIn), .irq(irq));
    pmp_peer u_pmp_peer (.clk_sys(clk_sys), .wrPol(wrPol), .rdPol(rdPol), .csPol(1'b1),
        .rdByte(rdByte), .slvWr(slvWr), .slvRd(slvRd), .slvByte(slvByte), .pinOut(pinOut),
        .portDataIn(portDataIn), .writeStrobeIn(writeStrobeIn), .readStrobeIn(readStrobeIn));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : giveVerdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {16'h0000, d}};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask : apb

    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle

    // counts active pin cycles while chip select is active
    task automatic watch(input logic wp, input logic rp, input logic bp, input logic every,
                         output int nCs, output int nWr, output int nRd, output int nBe,
                         output logic [15:0] b);
        logic seen;
        logic prevWr;
        seen = 1'b0;
        prevWr = 1'b0;
        {nCs, nWr, nRd, nBe} = '0;
        b = 16'h0000;
        for (int i = 0; i < 100; i++) begin
            #1;
            if (pinOut.chipSelectOne === 1'b1) begin
                seen = 1'b1;
                nCs++;
                nWr += int'(pinOut.writeStrobe === wp);
                nRd += int'(pinOut.readStrobe === rp);
                nBe += int'(pinOut.byteEnable === bp);
                if (pinOut.writeStrobe === wp && (every || !prevWr))
                    b = {pinOut.portData, b[15:8]};
                prevWr = (pinOut.writeStrobe === wp);
            end else if (seen)
                break;
            @(posedge clk_sys);
        end
    endtask : watch

    task automatic xfer(input int i);
        logic [2:0]  pol;
        logic [1:0]  s;
        logic [1:0]  h;
        logic [3:0]  w;
        logic [15:0] d;
        logic [15:0] md;
        logic [15:0] b;
        logic        m1;
        logic        rdDir;
        logic        wide;
        int          nCs;
        int          nWr;
        int          nRd;
        int          nBe;
        int          per;
        int          tot;
        seed = lfsr(seed);
        {pol, s, h, d} = seed[22:0];
        w = i[3] ? {2'b00, seed[25:24]} + 4'h1 : 4'h0;
        {wide, rdDir, m1} = i[2:0];
        wrPol <= pol[1];
        rdPol <= pol[0];
        rdByte <= seed[31:24];
        md = {5'b00000, wide, 1'b1, m1, s, w, h};
        wr(OFF_MODE, md);
        wr(OFF_CONTROL, {8'h80, 4'h8, 1'b1, pol});
        if (rdDir)
            apb(1'b0, OFF_DATA, 16'h0000);
        else
            apb(1'b1, OFF_DATA, d);
        watch(pol[1], pol[0], pol[2], w == 0, nCs, nWr, nRd, nBe, b);
        per = (w == 0) ? 1 : w + 1;
        tot = (wide ? 2 : 1) * ((w == 0) ? 1 : s + h + w + 3);
        chk(nCs, tot);
        chk(nWr, (rdDir && !m1) ? 0 : (wide ? 2 : 1) * per);
        chk(nRd, !rdDir ? 0 : (m1 ? tot : (wide ? 2 : 1) * per));
        chk(nBe, wide ? tot : 0);
        if (!rdDir)
            chk(b, wide ? d : {d[7:0], 8'h00});
        else begin
            apb(1'b0, OFF_DATA, 16'h0000);
            chk(wide ? rd[15:0] : rd[7:0], wide ? {rdByte, rdByte} : rdByte);
            watch(pol[1], pol[0], pol[2], w == 0, nCs, nWr, nRd, nBe, b);
        end
        chk({pinOut.byteEnable, pinOut.writeStrobe, pinOut.readStrobe}, {29'h0, ~pol});
        apb(1'b0, OFF_MODE, 16'h0000);
        chk(rd, {16'h0000, md});
        apb(1'b0, OFF_IRQ_STATUS, 16'h0000);
        chk(rd[IRQ_DONE], 1'b1);
        wr(OFF_IRQ_CLEAR, 16'h0007);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, d);
    endtask : wr

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failCount++;
            giveVerdict();
        end
    end

    initial begin
        {nrst, slvWr, slvRd, wrPol, rdPol, rdByte, slvByte, failCount, checksDone, cyc} = '0;
        apbReq = '0;
        seed = 32'd76606;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        apb(1'b0, OFF_CONTROL, 16'h0000);
        chk(rd, CONTROL_RESET);
        apb(1'b0, OFF_MODE, 16'h0000);
        chk(rd, MODE_RESET);
        apb(1'b0, 8'h1C, 16'h0000);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        chk(irq, 1'b0);
        wr(OFF_ADDR, 16'h07FF);
        settle();
        chk(pinOut.portAddr, 11'h003);
        for (int i = 0; i < 16; i++)
            xfer(i);
        wr(OFF_IRQ_ENABLE, 16'h0001);
        wr(OFF_MODE, 16'h12FF);
        wr(OFF_CONTROL, 16'h8088);
        wr(OFF_DATA, 16'h00A5);
        apb(1'b0, OFF_MODE, 16'h0000);
        chk(rd[MODE_BUSY], 1'b1);
        wr(OFF_DATA, 16'h005A);
        watch(1'b0, 1'b0, 1'b0, 1'b0, dc, dc, dc, dc, db);
        apb(1'b0, OFF_ADDR, 16'h0000);
        chk(rd, 32'h0000_07FE);
        apb(1'b0, OFF_IRQ_STATUS, 16'h0000);
        chk(rd[1:0], 2'b11);
        chk(irq, 1'b1);
        wr(OFF_IRQ_ENABLE, 16'h0000);
        settle();
        chk(irq, 1'b0);
        wr(OFF_IRQ_ENABLE, 16'h0003);
        settle();
        chk(irq, 1'b1);
        wr(OFF_IRQ_CLEAR, 16'h0003);
        settle();
        chk(irq, 1'b0);
        seed = lfsr(seed);
        {wrPol, rdPol} <= 2'b10;
        wr(OFF_CONTROL, 16'h8002);
        wr(OFF_MODE, 16'h0000);
        slvByte <= seed[7:0];
        slvWr <= 1'b1;
        repeat (3) @(posedge clk_sys);
        slvWr <= 1'b0;
        apb(1'b0, OFF_DATA, 16'h0000);
        chk(rd[7:0], seed[7:0]);
        apb(1'b0, OFF_IRQ_STATUS, 16'h0000);
        chk(rd[IRQ_SLAVE], 1'b1);
        wr(OFF_DATA, 16'h00C3);
        slvRd <= 1'b1;
        settle();
        chk({pinOut.portDataOe, pinOut.portData}, {1'b1, 8'hC3});
        slvRd <= 1'b0;
        for (int p = 0; p < 4; p++) begin
            wr(OFF_CONTROL, p[0] ? 16'h8806 : 16'h8802);
            wr(OFF_ADDR, {15'h0000, p[1]});
            settle();
            chk(pinOut.byteEnable, p[1]);
        end
        giveVerdict();
    end
endmodule : tb_top
